// ==== logic/deea_top.sv ====
// Notes on behaviour
// R01 - read: clear select, set strobe, byte next cycle
// R02 - read byte held until next read or write
// R03 - software loads address and data before unlocking
// R04 - keys 0x55 then 0xAA then strobe starts write
// R05 - write strobe ignored while write enable clear
// R06 - enable must precede strobe in earlier write
// R07 - hardware never clears write enable
// R08 - control, address, data locked during write
// R09 - write end clears strobe, sets done flag
// R10 - software clears done flag itself
// R11 - software should mask interrupts during unlock
// R12 - software keeps write enable clear otherwise
// R13 - software should read back and compare
// R14 - counter times write, read strobe self-clears
`timescale 1ns/10ps
`default_nettype none
module deea_top #(
  parameter int ADDR_W       = 10,
  parameter int WRITE_CYCLES = deea_pkg::WRITE_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int CW    = $clog2(WRITE_CYCLES + 1);

  logic [7:0] mem [DEPTH];

  // state: one register and one next value each
  logic [7:0]             addr_low_reg;
  logic [7:0]             addr_low_next;
  logic [7:0]             addr_high_reg;
  logic [7:0]             addr_high_next;
  logic [7:0]             byte_data_reg;
  logic [7:0]             byte_data_next;
  logic                   msel_reg;
  logic                   msel_next;
  logic                   write_enable_bit_reg;
  logic                   write_enable_bit_next;
  logic                   wr_reg;
  logic                   wr_next;
  logic                   rd_reg;
  logic                   rd_next;
  logic                   done_reg;
  logic                   done_next;
  logic                   mask_reg;
  logic                   mask_next;
  logic [CW-1:0]          cnt_reg;
  logic [CW-1:0]          cnt_next;
  deea_pkg::deea_unlock_e unlk_reg;
  deea_pkg::deea_unlock_e unlk_next;

  // next values of the registered outputs
  logic [31:0]            prdata_next;
  logic                   pready_next;
  logic                   pslverr_next;
  logic                   irq_next;

  // decoded access and address
  logic                   access;
  logic                   wr_acc;
  logic                   rd_acc;
  logic                   open_wr;
  logic                   start;
  logic                   finish;
  logic                   known;
  logic                   sel_addr_low;
  logic                   sel_addr_high;
  logic                   sel_byte_data;
  logic                   sel_control;
  logic                   sel_unlock;
  logic                   sel_status;
  logic                   sel_mask;
  logic [ADDR_W-1:0]      eaddr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // one wait state: pready rises in the second access cycle
  assign access  = psel && penable && !pready;
  assign wr_acc  = access && pwrite;
  assign rd_acc  = access && !pwrite;
  // the lock covers address, data and control while the write runs
  assign open_wr = wr_acc && !wr_reg; // see R08
  assign eaddr   = ADDR_W'({addr_high_reg, addr_low_reg});
  assign finish  = wr_reg && (cnt_reg == CW'(1));

  assign sel_addr_low  = hit(paddr, deea_pkg::ADDR_LOW_OFF);
  assign sel_addr_high = hit(paddr, deea_pkg::ADDR_HIGH_OFF);
  assign sel_byte_data = hit(paddr, deea_pkg::BYTE_DATA_OFF);
  assign sel_control   = hit(paddr, deea_pkg::NV_CONTROL_OFF);
  assign sel_unlock    = hit(paddr, deea_pkg::UNLOCK_KEY_OFF);
  assign sel_status    = hit(paddr, deea_pkg::IRQ_STATUS_OFF);
  assign sel_mask      = hit(paddr, deea_pkg::IRQ_MASK_OFF);
  assign known         = sel_addr_low || sel_addr_high || sel_byte_data || sel_control
                      || sel_unlock || sel_status || sel_mask;

  // old write enable must already be set, and the keys armed
  assign start = open_wr && sel_control && pwdata[deea_pkg::WR_BIT] // see R05
              && write_enable_bit_reg // see R06
              && (unlk_reg == deea_pkg::UNLK_ARMED); // see R04

  // address pair and data byte
  always_comb begin
    addr_low_next  = addr_low_reg;
    addr_high_next = addr_high_reg;
    byte_data_next = byte_data_reg;
    // read returns the byte one cycle after the strobe
    if (rd_reg && !msel_reg) begin
      byte_data_next = mem[eaddr]; // see R01 R02
    end
    if (open_wr && sel_addr_low) begin
      addr_low_next = pwdata[7:0]; // see R03
    end
    if (open_wr && sel_addr_high) begin
      addr_high_next = pwdata[7:0]; // see R03
    end
    if (open_wr && sel_byte_data) begin
      byte_data_next = pwdata[7:0]; // see R02 R03
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      addr_low_reg  <= 8'h00;
      addr_high_reg <= 8'h00;
      byte_data_reg <= 8'h00;
    end else begin
      addr_low_reg  <= addr_low_next;
      addr_high_reg <= addr_high_next;
      byte_data_reg <= byte_data_next;
    end
  end

  // select, write enable and read strobe
  always_comb begin
    msel_next = msel_reg;
    write_enable_bit_next = write_enable_bit_reg; // see R07
    rd_next   = 1'h0; // see R14
    if (open_wr && sel_control) begin
      msel_next = pwdata[deea_pkg::MSEL_BIT];
      write_enable_bit_next = pwdata[deea_pkg::WRITE_ENABLE_BIT_BIT]; // see R07
      rd_next   = pwdata[deea_pkg::RD_BIT] && !pwdata[deea_pkg::MSEL_BIT]; // see R01
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      msel_reg <= 1'h0;
      write_enable_bit_reg <= 1'h0;
      rd_reg   <= 1'h0;
    end else begin
      msel_reg <= msel_next;
      write_enable_bit_reg <= write_enable_bit_next;
      rd_reg   <= rd_next;
    end
  end

  // programming timer, write strobe and done flag
  always_comb begin
    wr_next   = wr_reg;
    cnt_next  = cnt_reg;
    done_next = done_reg;
    if (wr_reg) begin
      cnt_next = cnt_reg - CW'(1); // see R14
    end
    // the strobe stays up for the full count; it ends when the count reaches one
    if (start) begin
      wr_next  = 1'h1; // see R04 R05 R06
      cnt_next = CW'(WRITE_CYCLES); // see R14
    end
    // the flag is sticky: a new write leaves it alone, only software clears it
    if (wr_acc && sel_status && pwdata[deea_pkg::DONE_BIT]) begin
      done_next = 1'h0; // see R10
    end
    // set wins, so a clear landing on the last cycle cannot lose an event
    if (finish) begin
      wr_next   = 1'h0; // see R09
      done_next = 1'h1; // see R09
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_reg   <= 1'h0;
      cnt_reg  <= '0;
      done_reg <= 1'h0;
    end else begin
      wr_reg   <= wr_next;
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  // interrupt mask and level output
  always_comb begin
    mask_next = mask_reg;
    if (wr_acc && sel_mask) begin
      mask_next = pwdata[deea_pkg::DONE_BIT];
    end
    irq_next = done_next && mask_next; // see R09
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= 1'h0;
      irq      <= 1'h0;
    end else begin
      mask_reg <= mask_next;
      irq      <= irq_next;
    end
  end

  // any other register write breaks the key sequence
  always_comb begin
    unlk_next = unlk_reg;
    if (wr_acc) begin
      if (sel_unlock) begin
        case (unlk_reg)
          deea_pkg::UNLK_IDLE: begin
            unlk_next = (pwdata[7:0] == deea_pkg::KEY_FIRST) ? deea_pkg::UNLK_KEY1
                                                             : deea_pkg::UNLK_IDLE;
          end
          deea_pkg::UNLK_KEY1: begin
            unlk_next = (pwdata[7:0] == deea_pkg::KEY_SECOND) ? deea_pkg::UNLK_ARMED
                                                              : deea_pkg::UNLK_IDLE;
          end
          default: begin
            unlk_next = deea_pkg::UNLK_IDLE; // see R04
          end
        endcase
      end else begin
        unlk_next = deea_pkg::UNLK_IDLE; // see R04
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      unlk_reg <= deea_pkg::UNLK_IDLE;
    end else begin
      unlk_reg <= unlk_next;
    end
  end

  // bus answer; the key register reads as zero so the keys never leak
  always_comb begin
    prdata_next  = prdata;
    pready_next  = access;
    pslverr_next = access && !known;
    if (rd_acc) begin
      prdata_next = '0;
      if (sel_addr_low) begin
        prdata_next[7:0] = addr_low_reg;
      end
      if (sel_addr_high) begin
        prdata_next[7:0] = addr_high_reg;
      end
      if (sel_byte_data) begin
        prdata_next[7:0] = byte_data_reg;
      end
      if (sel_control) begin
        prdata_next[deea_pkg::MSEL_BIT] = msel_reg;
        prdata_next[deea_pkg::WRITE_ENABLE_BIT_BIT] = write_enable_bit_reg;
        prdata_next[deea_pkg::WR_BIT]   = wr_reg;
        prdata_next[deea_pkg::RD_BIT]   = rd_reg;
      end
      if (sel_status) begin
        prdata_next[deea_pkg::DONE_BIT] = done_reg;
      end
      if (sel_mask) begin
        prdata_next[deea_pkg::DONE_BIT] = mask_reg;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'h0;
      pslverr <= 1'h0;
    end else begin
      prdata  <= prdata_next;
      pready  <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // array has no reset; contents are the nonvolatile store
  // a reset in mid-write drops the byte, since the store is only written at the end
  always_ff @(posedge clock) begin
    if (finish) begin
      mem[eaddr] <= byte_data_reg; // see R09
    end
  end
endmodule
`default_nettype wire

// ==== logic/deea_pkg.sv ====
`default_nettype none
package deea_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] ADDR_LOW_OFF   = 8'h00;
  localparam logic [7:0] ADDR_HIGH_OFF  = 8'h04;
  localparam logic [7:0] BYTE_DATA_OFF  = 8'h08;
  localparam logic [7:0] NV_CONTROL_OFF = 8'h0C;
  localparam logic [7:0] UNLOCK_KEY_OFF = 8'h10;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFF   = 8'h18;
  // control register bit positions
  localparam int RD_BIT   = 0;
  localparam int WR_BIT   = 1;
  localparam int WRITE_ENABLE_BIT_BIT = 2;
  localparam int MSEL_BIT = 7;
  // irq status bit positions
  localparam int DONE_BIT = 0;
  // unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // programming time
  localparam int WRITE_TIME_NS = 40000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    UNLK_IDLE,
    UNLK_KEY1,
    UNLK_ARMED
  } deea_unlock_e;
endpackage
`default_nettype wire

// ==== test/deea_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module deea_checker (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic rd_done;
  assign rd_done = pready && !pwrite;
  a_access_wait: assert property (psel && penable && !pready |=> pready)
    else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_ready_cause: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("ready without access");
  a_err_unmapped: assert property (pready && paddr > 8'h18 |-> pslverr)
    else $error("no error on unmapped");
  a_err_mapped: assert property (pready && paddr[1:0] == 2'h0 && paddr <= 8'h18 |-> !pslverr)
    else $error("error on mapped");
  a_key_reads_zero: assert property (rd_done && paddr == 8'h10 |-> prdata == 32'h0)
    else $error("unlock key readable");
  a_rd_selfclear: assert property (rd_done && paddr == 8'h0C |-> !prdata[0])
    else $error("read strobe stuck");
  a_irq_flag: assert property (rd_done && paddr == 8'h14 && !prdata[0] |-> !irq)
    else $error("irq without flag");
  cover property (rd_done && paddr == 8'h0C && prdata[1]);
  cover property ($rose(irq));
  cover property (pready && pslverr);
endmodule
bind deea_top deea_checker chk (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module testbench;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} deea_row_s;
  logic        clock, nrst, psel, penable, pwrite, pready, pslverr, irq, re;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  int          n_mismatch = 0;
  int          check_count = 0;
  localparam logic [7:0] CTL = 8'h0C;
  localparam logic [7:0] KEY = 8'h10;
  localparam logic [7:0] DAT = 8'h08;
  localparam logic [7:0] STS = 8'h14;
  deea_row_s rows[7] = '{'{8'h00, 32'h123, 32'h23, 1'h0}, '{8'h04, 32'h1, 32'h1, 1'h0},
    '{8'h08, 32'h15A, 32'h5A, 1'h0}, '{8'h18, 32'h1, 32'h1, 1'h0}, '{KEY, 32'h55, 32'h0, 1'h0},
    '{STS, 32'h1, 32'h0, 1'h0}, '{8'h1C, 32'h7, 32'h0, 1'h1}};
  deea_top #(.WRITE_CYCLES(40)) uut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  // the request is held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin @(posedge clock); end while (pready !== 1'h1);
    rv = prdata;
    re = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic try_wr(input logic [7:0] pre, k1, k2, go, ex);
    apb(1'h1, 8'h18, 32'h0);
    apb(1'h1, CTL, {24'h0, pre});
    apb(1'h1, KEY, {24'h0, k1});
    apb(1'h1, KEY, {24'h0, k2});
    apb(1'h1, CTL, {24'h0, go});
    apb(1'h0, CTL, 32'h0);
    `CHK("ctrl", ex, rv[7:0])
  endtask
  task give_verdict;
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (16) @(posedge clock);
    nrst <= 1'h1;
    foreach (rows[i]) begin
      apb(1'h1, rows[i].a, rows[i].d);
      apb(1'h0, rows[i].a, 32'h0);
      `CHK("rdata", rows[i].x, rv)
      `CHK("perr", rows[i].e, re)
    end
    try_wr(8'h04, 8'h55, 8'hAA, 8'h06, 8'h06);
    apb(1'h1, DAT, 32'h11);
    apb(1'h1, CTL, 32'h0);
    apb(1'h0, CTL, 32'h0);
    `CHK("locked", 8'h06, rv[7:0])
    repeat (20) if (rv[1]) apb(1'h0, CTL, 32'h0);
    `CHK("ctrl end", 8'h04, rv[7:0])
    `CHK("irq masked", 1'h0, irq)
    apb(1'h1, 8'h18, 32'h1);
    `CHK("irq", 1'h1, irq)
    apb(1'h1, CTL, 32'h0);
    apb(1'h0, DAT, 32'h0);
    `CHK("data", 32'h5A, rv)
    apb(1'h1, STS, 32'h1);
    apb(1'h0, STS, 32'h0);
    `CHK("status", 32'h0, rv)
    `CHK("irq off", 1'h0, irq)
    apb(1'h1, DAT, 32'h0);
    apb(1'h1, CTL, 32'h1);
    apb(1'h0, DAT, 32'h0);
    `CHK("readback", 32'h5A, rv)
    apb(1'h0, DAT, 32'h0);
    `CHK("held", 32'h5A, rv)
    apb(1'h1, DAT, 32'h33);
    apb(1'h1, CTL, 32'h81);
    apb(1'h0, DAT, 32'h0);
    `CHK("select", 32'h33, rv)
    apb(1'h0, CTL, 32'h0);
    `CHK("sel bit", 32'h80, rv)
    try_wr(8'h00, 8'h55, 8'hAA, 8'h06, 8'h04);
    try_wr(8'h00, 8'h55, 8'hAA, 8'h02, 8'h00);
    try_wr(8'h04, 8'hAA, 8'h55, 8'h06, 8'h04);
    nrst <= 1'h0;
    @(posedge clock);
    nrst <= 1'h1;
    apb(1'h1, KEY, 32'h55);
    apb(1'h1, KEY, 32'hAA);
    apb(1'h1, CTL, 32'h06);
    apb(1'h0, CTL, 32'h0);
    `CHK("after reset", 32'h04, rv)
    give_verdict();
  end
endmodule
`default_nettype wire
